// File: core/pvp_port.sv
// parallel video port core: general-purpose and ITU-R 656 capture and transmit
// assumes the port sample clock is at most half of CLOCK; pins are resolved by the
// surrounding pad logic from the *_OE outputs
module pvp_port import pvp_pkg::*;
(
  // system
  input wire logic CLOCK,
  input wire logic RST_B,
  // port pins
  input wire logic PORT_SAMPLE_CLOCK, // R1
  input wire logic [FS_N-1:0] FRAME_SYNC_IN,
  output logic [FS_N-1:0] FRAME_SYNC_OUT,
  output logic [FS_N-1:0] FRAME_SYNC_OE,
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic [DATA_W-1:0] DATA_OE,
  // port control
  input wire logic PORT_ENABLE,
  input wire logic [2:0] PORT_MODE,
  input wire logic [2:0] DATA_WIDTH,
  input wire logic [1:0] FRAME_SYNC_COUNT,
  input wire logic [CNT_W-1:0] SYNC_TO_DATA_DELAY,
  input wire logic [CNT_W-1:0] SAMPLE_COUNT,
  input wire logic [CNT_W-1:0] LINE_BLANK,
  input wire logic [CNT_W-1:0] LINES_PER_FRAME,
  // memory side, receive
  output logic [DATA_W-1:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  // memory side, transmit
  input wire logic [DATA_W-1:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  // status
  output logic BUSY,
  output logic FIELD_LOCKED,
  output logic XFER_ERROR
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic pclk_s;
  logic [PIN_W-1:0] pin_s;
  logic pclk_d_r;
  logic pedge;
  logic [FS_N-1:0] fs_in;
  logic [DATA_W-1:0] din;

  pvp_sync2 #(.W(1)) u_sync_clk
  (
    .clk(CLOCK),
    .rst_b(RST_B),
    .d(PORT_SAMPLE_CLOCK),
    .q(pclk_s)
  );

  // same latency as the clock path, so data aligns with the edge
  pvp_sync2 #(.W(PIN_W)) u_sync_pins
  (
    .clk(CLOCK),
    .rst_b(RST_B),
    .d({FRAME_SYNC_IN, DATA_IN}),
    .q(pin_s)
  );

  assign fs_in = pin_s[PIN_W-1:DATA_W];
  assign din = pin_s[DATA_W-1:0];

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      pclk_d_r <= 1'b0;
    else
      pclk_d_r <= pclk_s;
  end

  // edges are only seen up to half of CLOCK
  assign pedge = pclk_s && !pclk_d_r; // R2

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  pvp_mode_t mode;
  logic en, is_itu, gp_rx, gp_tx, gen_sync, itu_rx, itu_tx;
  logic [DATA_W-1:0] wmask;
  logic [4:0] wbits;

  assign mode = pvp_mode_t'(PORT_MODE); // R15
  assign en = PORT_ENABLE;
  assign is_itu = PORT_MODE[2];
  assign gp_rx = mode == MODE_GP_INPUT || mode == MODE_GP_FRAME; // R4
  assign gp_tx = mode == MODE_GP_OUTPUT; // R4
  assign gen_sync = mode == MODE_GP_FRAME || mode == MODE_GP_OUTPUT;
  assign itu_rx = is_itu && mode != MODE_ITU_TX; // R5
  assign itu_tx = mode == MODE_ITU_TX; // R5
  assign wbits = WIDTH_BASE + {2'b00, DATA_WIDTH};
  assign wmask = (DATA_WIDTH == WIDTH_CODE_8) ? MASK_8 : ~(16'hffff << wbits); // R13

  // ----------------------------------------------------------------
  // line and frame timing for generated frame syncs
  // ----------------------------------------------------------------
  logic [POS_W-1:0] lpos_r;
  logic [CNT_W-1:0] line_r;
  logic [POS_W-1:0] line_last;
  logic line_end, line_start;
  logic field_r;

  assign line_last = {2'b00, SYNC_TO_DATA_DELAY} + {2'b00, SAMPLE_COUNT} + {2'b00, LINE_BLANK};
  assign line_end = lpos_r == line_last;
  assign line_start = lpos_r == POS_RST;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      lpos_r <= POS_RST;
      line_r <= CNT_RST;
      field_r <= 1'b0;
    end
    else if (!en || !gen_sync)
    begin
      lpos_r <= POS_RST;
      line_r <= CNT_RST;
      field_r <= 1'b0;
    end
    else if (pedge)
    begin
      lpos_r <= line_end ? POS_RST : lpos_r + 18'h00001;
      if (line_end)
      begin
        if (line_r + 16'h0001 >= LINES_PER_FRAME)
        begin
          line_r <= CNT_RST;
          field_r <= !field_r;
        end
        else
          line_r <= line_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sync and data drivers
  // ----------------------------------------------------------------
  logic [FS_N-1:0] fs_out_r, fs_oe_r;
  logic [DATA_W-1:0] data_oe_r;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      fs_out_r <= FS_RST;
    else if (!en || !gen_sync)
      fs_out_r <= FS_RST;
    else if (pedge)
    begin
      fs_out_r[0] <= line_start; // R14
      fs_out_r[1] <= line_start && line_r == CNT_RST; // R14
      fs_out_r[2] <= field_r; // R9
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      fs_oe_r <= FS_OE_NONE;
      data_oe_r <= DATA_RST;
    end
    else
    begin
      if (en && mode == MODE_GP_FRAME)
        fs_oe_r <= FS_OE_TWO; // R8
      else if (en && gp_tx)
        unique case (FRAME_SYNC_COUNT) // R9
          2'h2: fs_oe_r <= FS_OE_TWO;
          2'h3: fs_oe_r <= FS_OE_ALL;
          default: fs_oe_r <= FS_OE_ONE;
        endcase
      else
        fs_oe_r <= FS_OE_NONE; // R3 R7
      data_oe_r <= (en && (gp_tx || itu_tx)) ? wmask : DATA_RST; // R7 R9
    end
  end

  // ----------------------------------------------------------------
  // general-purpose sequencer
  // ----------------------------------------------------------------
  pvp_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic fs1_d_r;
  logic sync_ev;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      fs1_d_r <= 1'b0;
    else if (pedge)
      fs1_d_r <= fs_in[0];
  end

  // input mode follows the peripheral, others the line timer
  assign sync_ev = pedge && (gen_sync ? line_start : (fs_in[0] && !fs1_d_r)); // R10

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_r <= ST_WAIT;
      cnt_r <= CNT_RST;
    end
    else if (!en || is_itu)
    begin
      state_r <= ST_WAIT;
      cnt_r <= CNT_RST;
    end
    else if (pedge)
    begin
      unique case (state_r)
        ST_WAIT:
        begin
          cnt_r <= CNT_RST;
          if (sync_ev && SAMPLE_COUNT != CNT_RST)
          begin
            if (SYNC_TO_DATA_DELAY == CNT_RST)
              state_r <= ST_MOVE;
            else
            begin
              state_r <= ST_DELAY; // R11
              cnt_r <= SYNC_TO_DATA_DELAY;
            end
          end
        end
        ST_DELAY:
        begin
          cnt_r <= cnt_r - 16'h0001; // R11
          if (cnt_r == 16'h0001)
          begin
            state_r <= ST_MOVE;
            cnt_r <= CNT_RST;
          end
        end
        ST_MOVE:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 >= SAMPLE_COUNT)
            state_r <= ST_WAIT; // R12
        end
        default:
          state_r <= ST_WAIT;
      endcase
    end
  end

  logic gp_cap, gp_drive;
  assign gp_cap = pedge && state_r == ST_MOVE && gp_rx; // R12
  assign gp_drive = pedge && state_r == ST_MOVE && gp_tx; // R9

  // ----------------------------------------------------------------
  // ITU-R 656 receive path
  // ----------------------------------------------------------------
  pvp_itu_if itu ();

  assign itu.smp = (DATA_WIDTH == WIDTH_CODE_8) ? {din[7:0], 2'b00} : din[ITU_W-1:0]; // R5
  assign itu.smp_stb = pedge && en && itu_rx;

  pvp_itu_decode u_decode
  (
    .clk(CLOCK),
    .rst_b(RST_B),
    .itu(itu.dec)
  );

  logic locked_r, f_prev_r, act_r, vbl_r, line_ok_r;
  logic [CNT_W-1:0] lines_r, lines_now;
  logic field_one, sav_code;

  assign field_one = itu.code_stb && !itu.fld && f_prev_r;
  assign sav_code = itu.code_stb && !itu.hrz && !itu.vbl;
  assign lines_now = field_one ? CNT_RST : lines_r;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      locked_r <= 1'b0;
      f_prev_r <= 1'b0;
      act_r <= 1'b0;
      vbl_r <= 1'b0;
      line_ok_r <= 1'b0;
      lines_r <= CNT_RST;
    end
    else if (!en || !itu_rx)
    begin
      locked_r <= 1'b0;
      f_prev_r <= 1'b0;
      act_r <= 1'b0;
      vbl_r <= 1'b0;
      line_ok_r <= 1'b0;
      lines_r <= CNT_RST;
    end
    else if (itu.code_stb)
    begin
      f_prev_r <= itu.fld;
      vbl_r <= itu.vbl;
      // act_r only rises on SAV, so samples before it are ignored
      act_r <= !itu.hrz && !itu.vbl; // R16 R18
      if (field_one)
      begin
        locked_r <= 1'b1; // R18 R21
        lines_r <= CNT_RST;
      end
      if (sav_code)
      begin
        line_ok_r <= lines_now < SAMPLE_COUNT; // R19
        if (lines_now < SAMPLE_COUNT)
          lines_r <= lines_now + 16'h0001;
      end
    end
  end

  logic itu_fwd;

  always_comb
  begin
    itu_fwd = 1'b0;
    if (itu.word_stb && locked_r)
      unique case (mode)
        MODE_ITU_ACTIVE: itu_fwd = act_r && line_ok_r && !itu.word_pre; // R16 R17 R19
        MODE_ITU_VBLANK: itu_fwd = vbl_r && !itu.word_pre; // R20
        MODE_ITU_FIELD: itu_fwd = 1'b1; // R21
        default: itu_fwd = 1'b0;
      endcase
  end

  // ----------------------------------------------------------------
  // receive holding register toward memory
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rx_data_r, rx_src;
  logic rx_valid_r, push, overrun;

  assign rx_src = gp_cap ? (din & wmask)
                : (DATA_WIDTH == WIDTH_CODE_8) ? {8'h00, itu.word[9:2]} : {6'h00, itu.word};
  assign push = gp_cap || itu_fwd;
  // a held word is never overwritten; the newcomer is lost instead
  assign overrun = push && rx_valid_r && !RX_READY;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_data_r <= DATA_RST;
      rx_valid_r <= 1'b0;
    end
    else if (push && (!rx_valid_r || RX_READY))
    begin
      rx_data_r <= rx_src; // R22
      rx_valid_r <= 1'b1;
    end
    else if (RX_READY || !en)
      rx_valid_r <= 1'b0; // R22
  end

  // ----------------------------------------------------------------
  // transmit holding register and data driver
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] tx_data_r, data_out_r;
  logic tx_full_r, drive, underrun;

  assign TX_READY = en && (gp_tx || itu_tx) && !tx_full_r;
  assign drive = gp_drive || (pedge && en && itu_tx);
  assign underrun = drive && !tx_full_r;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tx_data_r <= DATA_RST;
      tx_full_r <= 1'b0;
    end
    else if (TX_VALID && TX_READY)
    begin
      tx_data_r <= TX_DATA;
      tx_full_r <= 1'b1;
    end
    else if (drive || !en)
      tx_full_r <= 1'b0;
  end

  // on underrun the last word stays on the pins
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      data_out_r <= DATA_RST;
    else if (drive && tx_full_r)
      data_out_r <= tx_data_r & wmask; // R9 R13
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  logic err_r;

  // a new error wins over the clear by disable
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      err_r <= 1'b0;
    else if (overrun || underrun)
      err_r <= 1'b1;
    else if (!en)
      err_r <= 1'b0;
  end

  assign FRAME_SYNC_OUT = fs_out_r;
  assign FRAME_SYNC_OE = fs_oe_r;
  assign DATA_OUT = data_out_r;
  assign DATA_OE = data_oe_r;
  assign RX_DATA = rx_data_r;
  assign RX_VALID = rx_valid_r;
  assign BUSY = state_r != ST_WAIT;
  assign FIELD_LOCKED = locked_r;
  assign XFER_ERROR = err_r;

endmodule

// File: include/pvp_pkg.sv
// package for the parallel video port: modes, states, field positions, reset values
// assumes one system clock domain; the port sample clock is sampled, not used as a clock
//
// Functional notes
// R1: one sample clock input, three frame sync lines, sixteen data lines
// R2: port sample clock must stay at or below half the system clock rate
// R3: each frame sync line is an input or a driven output, per mode
// R4: general-purpose modes move up to sixteen-bit words, receive or transmit
// R5: ITU-R 656 modes move 8- or 10-bit samples, receive or transmit
// R6: embedded line and field preambles are decoded from incoming samples
// R7: input submode treats every frame sync and data line as input
// R8: frame capture drives frame syncs while data lines are received
// R9: output submode drives data lines and up to three frame syncs
// R10: input submode starts sampling from the first frame sync line
// R11: wait sync_to_data_delay port clocks after sync before reading data
// R12: capture exactly sample_count samples per frame sync, then stop
// R13: data width is 8 bits or any of 10 to 16 bits
// R14: frame capture drives sync one as horizontal, sync two as vertical
// R15: three ITU submodes, exactly one selected at a time
// R16: active video only drops EAV-to-SAV samples and vertical blanking samples
// R17: active video only never forwards preamble words
// R18: after locking to field one, ignore samples until an SAV code
// R19: active video only transfers sample_count lines per frame
// R20: vertical blanking only forwards blanking-interval samples alone
// R21: entire field forwards every sample right after locking to field one
// R22: captured words held stable on a valid/ready handshake until accepted
package pvp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int FS_N = 3;
  localparam int ITU_W = 10;
  localparam int CNT_W = 16;
  localparam int POS_W = 18;
  localparam int PIN_W = FS_N + DATA_W;

  // ----------------------------------------------------------------
  // width codes: 0 is 8 bits, code n is 9+n bits
  // ----------------------------------------------------------------
  localparam logic [2:0] WIDTH_CODE_8 = 3'h0;
  localparam logic [4:0] WIDTH_BASE = 5'h09;
  localparam logic [15:0] MASK_8 = 16'h00ff;

  // ----------------------------------------------------------------
  // preamble words and XY bit positions (within the upper 8 bits)
  // ----------------------------------------------------------------
  localparam logic [7:0] PRE_ONES = 8'hff;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam int XY_F_BIT = 6;
  localparam int XY_V_BIT = 5;
  localparam int XY_H_BIT = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [2:0] FS_RST = 3'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [17:0] POS_RST = 18'h00000;
  localparam logic [9:0] ITU_RST = 10'h000;
  localparam logic [3:0] KILL_ALL = 4'hf;
  localparam logic [3:0] KILL_NONE = 4'h0;

  // ----------------------------------------------------------------
  // frame sync enables per mode
  // ----------------------------------------------------------------
  localparam logic [2:0] FS_OE_NONE = 3'h0;
  localparam logic [2:0] FS_OE_ONE = 3'h1;
  localparam logic [2:0] FS_OE_TWO = 3'h3;
  localparam logic [2:0] FS_OE_ALL = 3'h7;

  // port clock must give at least this many system clocks per period
  localparam int PCLK_MIN_DIV = 2;

  typedef enum logic [2:0] {
    MODE_GP_INPUT = 3'h0,
    MODE_GP_FRAME = 3'h1,
    MODE_GP_OUTPUT = 3'h2,
    MODE_ITU_ACTIVE = 3'h4,
    MODE_ITU_VBLANK = 3'h5,
    MODE_ITU_FIELD = 3'h6,
    MODE_ITU_TX = 3'h7
  } pvp_mode_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_DELAY = 2'b01,
    ST_MOVE = 2'b11
  } pvp_state_t;

endpackage

// File: include/pvp_itu_if.sv
// carrier between the port core and the preamble decoder
// assumes both ends run on the same system clock
interface pvp_itu_if;
  import pvp_pkg::*;
  logic [ITU_W-1:0] smp;
  logic smp_stb;
  logic [ITU_W-1:0] word;
  logic word_stb;
  logic word_pre;
  logic code_stb;
  logic fld;
  logic vbl;
  logic hrz;
  modport dec (input smp, smp_stb, output word, word_stb, word_pre, code_stb, fld, vbl, hrz);
  modport core (output smp, smp_stb, input word, word_stb, word_pre, code_stb, fld, vbl, hrz);
endinterface

// File: core/pvp_sync2.sv
// two-flop synchroniser for a bundle of pin levels
// assumes each bit is a slow level; bits are not coherent with each other
module pvp_sync2 import pvp_pkg::*;
#(
  parameter int W = 1
)
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// File: core/pvp_itu_decode.sv
// ITU-R 656 preamble decoder: delays samples by three and flags preamble words
// assumes one smp_stb per port clock edge; compares the upper 8 of 10 bits
module pvp_itu_decode import pvp_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  // samples in, words out
  pvp_itu_if.dec itu
);

  logic [ITU_W-1:0] d0_r, d1_r, d2_r, d3_r;
  logic [3:0] kill_r;
  logic hit;
  logic word_stb_r, code_stb_r, fld_r, vbl_r, hrz_r;

  // the delay lets the FF 00 00 words be marked before they leave
  assign hit = itu.smp_stb && d2_r[9:2] == PRE_ONES && d1_r[9:2] == PRE_ZERO
               && d0_r[9:2] == PRE_ZERO; // R6

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      d0_r <= ITU_RST;
      d1_r <= ITU_RST;
      d2_r <= ITU_RST;
      d3_r <= ITU_RST;
      kill_r <= KILL_NONE;
    end
    else if (itu.smp_stb)
    begin
      d0_r <= itu.smp;
      d1_r <= d0_r;
      d2_r <= d1_r;
      d3_r <= d2_r;
      kill_r <= hit ? KILL_ALL : {kill_r[2:0], 1'b0}; // R6
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_stb_r <= 1'b0;
      code_stb_r <= 1'b0;
      fld_r <= 1'b0;
      vbl_r <= 1'b0;
      hrz_r <= 1'b0;
    end
    else
    begin
      word_stb_r <= itu.smp_stb;
      code_stb_r <= hit;
      if (hit)
      begin
        fld_r <= itu.smp[2 + XY_F_BIT];
        vbl_r <= itu.smp[2 + XY_V_BIT];
        hrz_r <= itu.smp[2 + XY_H_BIT];
      end
    end
  end

  assign itu.word = d3_r;
  assign itu.word_pre = kill_r[3];
  assign itu.word_stb = word_stb_r;
  assign itu.code_stb = code_stb_r;
  assign itu.fld = fld_r;
  assign itu.vbl = vbl_r;
  assign itu.hrz = hrz_r;

endmodule

// File: bench/pvp_port_sva.sv
// checker for the parallel video port: pin direction, width masking, receive handshake
// assumes one clock domain; modes change only while disabled
module pvp_port_sva import pvp_pkg::*;
(
  // system
  input wire logic CLOCK,
  input wire logic RST_B,
  // control
  input wire logic PORT_ENABLE,
  input wire logic [2:0] PORT_MODE,
  input wire logic [2:0] DATA_WIDTH,
  // pins
  input wire logic [FS_N-1:0] FRAME_SYNC_OE,
  input wire logic [DATA_W-1:0] DATA_OUT,
  input wire logic [DATA_W-1:0] DATA_OE,
  // memory side
  input wire logic [DATA_W-1:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic TX_READY,
  input wire logic FIELD_LOCKED
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [DATA_W-1:0] mask;
  logic itu_rx;
  assign mask = (DATA_WIDTH == WIDTH_CODE_8) ? MASK_8 : 16'hffff >> (3'h7 - DATA_WIDTH);
  assign itu_rx = PORT_MODE inside {MODE_ITU_ACTIVE, MODE_ITU_VBLANK, MODE_ITU_FIELD};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // enables are registered: judged one cycle into a mode
  chk_rx_word_held: assert property (PORT_ENABLE && RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
    else $error("receive word changed before acceptance");
  chk_input_pins_in: assert property ((PORT_ENABLE && PORT_MODE == MODE_GP_INPUT) [*2] |->
    FRAME_SYNC_OE == FS_OE_NONE && DATA_OE == 16'h0000) else $error("input mode drives a pin");
  chk_capture_syncs_out: assert property ((PORT_ENABLE && PORT_MODE == MODE_GP_FRAME) [*2] |->
    FRAME_SYNC_OE[1:0] == 2'h3 && DATA_OE == 16'h0000) else $error("frame capture pin directions wrong");
  chk_output_drives: assert property ((PORT_ENABLE && PORT_MODE == MODE_GP_OUTPUT) [*2] |->
    DATA_OE == mask) else $error("output mode data enables differ from width");
  chk_output_masked: assert property ((PORT_ENABLE && PORT_MODE == MODE_GP_OUTPUT) [*2] |->
    (DATA_OUT & ~mask) == 16'h0000) else $error("output data above width");
  chk_rx_masked: assert property (RX_VALID && PORT_MODE == MODE_GP_INPUT |->
    (RX_DATA & ~mask) == 16'h0000) else $error("received word above width");
  chk_tx_one_dir: assert property (TX_READY |->
    PORT_ENABLE && PORT_MODE inside {MODE_GP_OUTPUT, MODE_ITU_TX}) else $error("transmit ready in receive mode");
  chk_itu_pins_in: assert property ((PORT_ENABLE && itu_rx) [*2] |->
    FRAME_SYNC_OE == FS_OE_NONE && DATA_OE == 16'h0000) else $error("video receive drives a pin");
  chk_itu_after_lock: assert property (PORT_ENABLE && itu_rx && $rose(RX_VALID) |-> FIELD_LOCKED)
    else $error("video word before lock");
endmodule

bind pvp_port pvp_port_sva chk (.CLOCK(CLOCK), .RST_B(RST_B), .PORT_ENABLE(PORT_ENABLE),
  .PORT_MODE(PORT_MODE), .DATA_WIDTH(DATA_WIDTH), .FRAME_SYNC_OE(FRAME_SYNC_OE), .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_READY(TX_READY),
  .FIELD_LOCKED(FIELD_LOCKED));

// File: bench/pvp_peer.sv
// far-side model: sample clock, frame sync one and data words or a video stream
// assumes the bench resolves pins against the device's output enables
module pvp_peer
(
  // control from bench
  input wire logic run,
  input wire logic itu,
  // pins toward the device
  output logic pclk,
  output logic [2:0] fs,
  output logic [15:0] d
);
  timeunit 1ns;
  timeprecision 1ns;
  // field two code, lock code, a line, blanking, vertical codes
  localparam logic [9:0] TAB [27] = '{10'h3fc, 10'h000, 10'h000, 10'h300, 10'h3fc, 10'h000, 10'h000,
    10'h200, 10'h101, 10'h102, 10'h103, 10'h3fc, 10'h000, 10'h000, 10'h240, 10'h050, 10'h3fc, 10'h000,
    10'h000, 10'h2c0, 10'h111, 10'h112, 10'h3fc, 10'h000, 10'h000, 10'h280, 10'h113};
  int idx = 0;

  initial
  begin
    fs = 3'h0;
    d = 16'h0000;
  end

  // 800 ns period, below CLOCK/2; idle while run is low
  always
  begin
    pclk = 1'b0;
    wait (run);
    while (run)
    begin
      #400 pclk = 1'b1;
      #400 pclk = 1'b0;
    end
  end

  // released syncs clear and data lines invert so stale data cannot pass
  always @(negedge run)
  begin
    fs = 3'h0;
    d = ~d;
    idx = 0;
  end

  always @(negedge pclk)
  begin
    if (run && itu)
      d = (idx < 2 || idx > 28) ? 16'h0040 : {6'h00, TAB[idx-2]};
    else if (run)
    begin
      fs[0] = 1'b1;
      d = {8'ha5, idx[7:0]};
    end
    if (run) idx++;
  end
endmodule

// File: bench/test_pvp_port.sv
// self-checking bench for the parallel video port
// assumes pvp_peer on the pins, resolved by the device's enables
module test_pvp_port import pvp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst_b = 1'b0, en = 1'b0, run = 1'b0, itu = 1'b0, rx_ready = 1'b1, tx_valid = 1'b0;
  logic [2:0] mode = 3'h3, wcode = 3'h0;
  logic [1:0] fs_cnt = 2'h0;
  logic [15:0] dly = 16'h0000, cnt = 16'h0000, blank = 16'h0000, lines = 16'h0001, tx_data = 16'h0000;
  logic [2:0] fs_out, fs_oe, p_fs, fs_in;
  logic [15:0] d_out, d_oe, p_d, d_in, rx_data;
  logic pclk, rx_valid, tx_ready, busy, locked, xerr;
  logic [15:0] q[$];
  int fail_count = 0;
  int checks = 0;

  assign fs_in = (fs_oe & fs_out) | (~fs_oe & p_fs);
  assign d_in = (d_oe & d_out) | (~d_oe & p_d);

  pvp_peer peer (.run(run), .itu(itu), .pclk(pclk), .fs(p_fs), .d(p_d));
  pvp_port dut (.CLOCK(clock), .RST_B(rst_b), .PORT_SAMPLE_CLOCK(pclk), .FRAME_SYNC_IN(fs_in),
    .FRAME_SYNC_OUT(fs_out), .FRAME_SYNC_OE(fs_oe), .DATA_IN(d_in), .DATA_OUT(d_out), .DATA_OE(d_oe),
    .PORT_ENABLE(en), .PORT_MODE(mode), .DATA_WIDTH(wcode), .FRAME_SYNC_COUNT(fs_cnt),
    .SYNC_TO_DATA_DELAY(dly), .SAMPLE_COUNT(cnt), .LINE_BLANK(blank), .LINES_PER_FRAME(lines),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .BUSY(busy), .FIELD_LOCKED(locked), .XFER_ERROR(xerr));

  // ----------------------------------------
  // clock, collector, shared tasks
  // ----------------------------------------
  always #50 clock = ~clock;

  always @(posedge clock)
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      q.push_back(rx_data);

  task tick;
    @(posedge clock);
    #10;
  endtask

  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", n, exp, got);
      fail_count++;
    end
  endtask

  // modes change only while disabled, far side quiet
  task setup(input logic [2:0] m, input logic [2:0] w, input logic [15:0] dl, input logic [15:0] c);
    en = 1'b0;
    run = 1'b0;
    repeat (10) tick;
    mode = m;
    wcode = w;
    dly = dl;
    cnt = c;
    q.delete();
    en = 1'b1;
    run = 1'b1;
    tick;
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task gp_input;
    setup(MODE_GP_INPUT, WIDTH_CODE_8, 16'h0001, 16'h0002);
    repeat (300) if (q.size() < 2) tick;
    repeat (80) tick;
    chk("word_count", 16'(q.size()), 16'h0002);
    chk("first_word", q[0], 16'h0002);
    chk("second_word", q[1], 16'h0003);
    chk("busy", 16'(busy), 16'h0000);
    $display("test gp_input done");
  endtask

  task rx_stall;
    rx_ready = 1'b0;
    setup(MODE_GP_INPUT, 3'h7, 16'h0000, 16'h0002);
    repeat (300) if (rx_valid !== 1'b1) tick;
    repeat (40) tick;
    chk("held_word", rx_data, 16'ha501);
    chk("overrun", 16'(xerr), 16'h0001);
    rx_ready = 1'b1;
    tick;
    $display("test rx_stall done");
  endtask

  task frame_cap;
    blank = 16'h0002;
    lines = 16'h0002;
    setup(MODE_GP_FRAME, 3'h7, 16'h0001, 16'h0002);
    repeat (300) if (fs_out[0] !== 1'b1) tick;
    chk("line_sync", 16'(fs_out[0]), 16'h0001);
    chk("sync_oe", 16'(fs_oe[1:0]), 16'h0003);
    repeat (80) tick;
    repeat (300) if (fs_out[1] !== 1'b1) tick;
    chk("frame_sync", 16'(fs_out[1]), 16'h0001);
    chk("field_level", 16'(fs_out[2]), 16'h0001);
    chk("capture_words", 16'(q.size()), 16'h0004);
    $display("test frame_cap done");
  endtask

  task gp_output;
    fs_cnt = 2'h3;
    blank = 16'h0000;
    lines = 16'h0001;
    tx_data = 16'hffff;
    setup(MODE_GP_OUTPUT, 3'h1, 16'h0000, 16'h0004);
    tx_valid = 1'b1;
    repeat (300) if (d_out !== 16'h03ff) tick;
    chk("data_out", d_out, 16'h03ff);
    chk("sync_oe", 16'(fs_oe), 16'h0007);
    chk("data_oe", d_oe, 16'h03ff);
    tick;
    tx_valid = 1'b0;
    repeat (200) tick;
    chk("underrun", 16'(xerr), 16'h0001);
    $display("test gp_output done");
  endtask

  task itu_modes;
    logic [2:0] md [3];
    logic [15:0] e [3][3];
    md = '{MODE_ITU_ACTIVE, MODE_ITU_VBLANK, MODE_ITU_FIELD};
    e = '{'{16'h0101, 16'h0102, 16'h0103}, '{16'h0111, 16'h0112, 16'h0113}, '{16'h0000, 16'h0000, 16'h0200}};
    itu = 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      setup(md[m], 3'h1, 16'h0000, 16'h0001);
      repeat (320) tick;
      chk("field_locked", 16'(locked), 16'h0001);
      for (int i = 0; i < 3; i++)
        chk("video_word", q[i], e[m][i]);
      if (m == 0)
        chk("active_count", 16'(q.size()), 16'h0003);
    end
    itu = 1'b0;
    $display("test itu_modes done");
  endtask

  initial
  begin
    repeat (16) tick;
    rst_b = 1'b1;
    gp_input;
    rx_stall;
    frame_cap;
    gp_output;
    itu_modes;
    print_verdict;
  end

  // all scenarios need about 1600 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    $display("Error watchdog expected done seen hang");
    fail_count++;
    print_verdict;
  end
endmodule
